//--- spc_pkg.sv
// spc_pkg: shared constants and carrier types for sector protect control
// assumes a 40 MHz system clock; all users reference items as spc_pkg::name

package spc_pkg;

   // ==========================================================
   // clock and timing
   localparam int CLK_PERIOD_NS = 25;
   // write-protect noise filter window, in ns
   localparam int WP_FILT_NS    = 1000;
   // least time rounds up to whole cycles
   localparam int WP_FILT_CYC   =
      (WP_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // command bytes
   localparam logic [7:0] CMD_PFX0     = 8'h3D;
   localparam logic [7:0] CMD_PFX1     = 8'h2A;
   localparam logic [7:0] CMD_PFX2     = 8'h7F;
   localparam logic [7:0] CMD_PROT_ON  = 8'hA9;
   localparam logic [7:0] CMD_PROT_OFF = 8'h9A;

   // ==========================================================
   // selection register layout
   localparam int         SEL_BYTES    = 16;
   localparam int         SEL_IDX_W    = 4;
   localparam logic [7:0] SEL_MARKED   = 8'hFF;
   localparam logic [7:0] SEL_CLEAR    = 8'h00;
   localparam logic [7:0] SEL_ERASED   = 8'hFF;
   // contents after reset model the shipped state
   localparam logic [7:0] SEL_RST_VAL  = 8'h00;
   // sector 0 sub-sector fields
   localparam int         SUB_A_HI     = 7;
   localparam int         SUB_A_LO     = 6;
   localparam int         SUB_B_HI     = 5;
   localparam int         SUB_B_LO     = 4;

   // ==========================================================
   // reset values
   localparam logic SW_EN_RST = 1'b0;
   localparam logic WP_N_RST  = 1'b1;

   // ==========================================================
   // command decoder states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_PFX1  = 3'b001,
      ST_PFX2  = 3'b010,
      ST_LAST  = 3'b011,
      ST_ARMON = 3'b100,
      ST_ARMOF = 3'b101,
      ST_DEAD  = 3'b110
   } spc_cmd_st_t;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } spc_byte_t;

   typedef struct packed {
      logic                 valid;
      logic                 to_reg;   // target is the selection register
      logic [SEL_IDX_W-1:0] sector;
      logic                 sub_b;    // sector 0 only: upper part
   } spc_op_req_t;

   typedef struct packed {
      logic valid;
      logic blocked;
   } spc_verdict_t;

   typedef struct packed {
      logic                 valid;
      logic                 erase;    // set every byte to erased value
      logic [SEL_IDX_W-1:0] idx;
      logic [7:0]           data;
   } spc_sel_wr_t;

endpackage

//--- spc_spi_rx.sv
// spc_spi_rx: samples the serial pins with the system clock, frames bytes
// assumes pins are asynchronous; mode 0/3, data taken on sck rising edge

`timescale 1ns/1ps

module spc_spi_rx (
   // clock and reset
   input  wire logic              i_clk_sys,
   input  wire logic              i_reset,
   // serial pins
   input  wire logic              i_spi_sck,
   input  wire logic              i_spi_cs_n,
   input  wire logic              i_spi_si,
   // framed output
   output spc_pkg::spc_byte_t     o_byte,
   output logic                   o_frame_start,
   output logic                   o_frame_end,
   output logic                   o_mid_byte
);

   // ==========================================================
   // synchronisers
   logic [1:0] sck_s_r;
   logic [1:0] cs_s_r;
   logic [1:0] si_s_r;
   logic       sck_d_r;
   logic       cs_d_r;
   logic [2:0] bit_cnt_r;
   logic [6:0] shift_r;
   logic       sck_rise;

   // two flops per pin, second stage only is read
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         sck_s_r <= 2'b00;
         cs_s_r  <= 2'b11;
         si_s_r  <= 2'b00;
         sck_d_r <= 1'b0;
         cs_d_r  <= 1'b1;
      end else begin
         sck_s_r <= {sck_s_r[0], i_spi_sck};
         cs_s_r  <= {cs_s_r[0], i_spi_cs_n};
         si_s_r  <= {si_s_r[0], i_spi_si};
         sck_d_r <= sck_s_r[1];
         cs_d_r  <= cs_s_r[1];
      end
   end

   assign sck_rise      = sck_s_r[1] & ~sck_d_r & ~cs_s_r[1];
   assign o_frame_start = cs_d_r & ~cs_s_r[1];
   assign o_frame_end   = ~cs_d_r & cs_s_r[1];
   assign o_mid_byte    = (bit_cnt_r != 3'd0);

   // ==========================================================
   // bit shifter, msb first
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         bit_cnt_r <= 3'd0;
         shift_r   <= 7'd0;
         o_byte    <= '0;
      end else begin
         o_byte.valid <= 1'b0;
         if (cs_s_r[1]) begin
            bit_cnt_r <= 3'd0;
         end else if (sck_rise) begin
            bit_cnt_r <= bit_cnt_r + 3'd1;
            shift_r   <= {shift_r[5:0], si_s_r[1]};
            if (bit_cnt_r == 3'd7) begin
               o_byte.valid <= 1'b1;
               o_byte.data  <= {shift_r, si_s_r[1]};
            end
         end
      end
   end

endmodule

//--- spc_wp_filt.sv
// spc_wp_filt: synchronises and debounces the active-low write-protect pin
// assumes the pin is asynchronous; level accepted after a stable window

`timescale 1ns/1ps

module spc_wp_filt #(
   parameter int STABLE_CYC = spc_pkg::WP_FILT_CYC
) (
   // clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_reset,
   // pin and filtered level
   input  wire logic i_wp_n,
   output logic      o_wp_n_filt
);

   localparam int CW = $clog2(STABLE_CYC + 1);

   // ==========================================================
   // sync and stability counter
   logic [1:0]    wp_s_r;
   logic [CW-1:0] stab_cnt_r;

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         wp_s_r <= {2{spc_pkg::WP_N_RST}};
      end else begin
         wp_s_r <= {wp_s_r[0], i_wp_n};
      end
   end

   // new level taken only after it held the whole window
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         stab_cnt_r  <= '0;
         o_wp_n_filt <= spc_pkg::WP_N_RST;
      end else if (wp_s_r[1] == o_wp_n_filt) begin
         stab_cnt_r <= '0;
      end else if (stab_cnt_r == CW'(STABLE_CYC - 1)) begin
         stab_cnt_r  <= '0;
         o_wp_n_filt <= wp_s_r[1];
      end else begin
         stab_cnt_r <= stab_cnt_r + CW'(1);
      end
   end

endmodule

//--- spc_sector_protect.sv
// spc_sector_protect: software/hardware sector protection control
// assumes serial pins and write-protect pin are asynchronous to i_clk_sys;
// program/erase engines ask for verdicts and write the selection register
// verdict requests and register writes come from logic on i_clk_sys and
// pass no synchroniser; the status flags lag each pin by its sync and
// filter latency, so engines must not act on a flag mid-change

`timescale 1ns/1ps

module spc_sector_protect #(
   parameter int WP_STABLE_CYC = spc_pkg::WP_FILT_CYC
) (
   // clock and reset
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_reset,
   // serial command pins
   input  wire logic                 i_spi_sck,
   input  wire logic                 i_spi_cs_n,
   input  wire logic                 i_spi_si,
   // write-protect pin
   input  wire logic                 i_wp_n,
   // program/erase permission check
   input  wire spc_pkg::spc_op_req_t i_op_req,
   output spc_pkg::spc_verdict_t     o_op_verdict,
   // selection register write and read
   input  wire spc_pkg::spc_sel_wr_t i_sel_wr,
   output logic                      o_sel_wr_done,
   output logic                      o_sel_wr_refused,
   input  wire logic [3:0]           i_sel_rd_idx,
   output logic [7:0]                o_sel_rd_data,
   // status
   output logic                      o_prot_en,
   output logic                      o_sel_wr_ok
);

   // ==========================================================
   // decoding used by the verdict and the software enable
   // sector 0 is split in two parts of two bits each; any value other
   // than the marked pattern reads as unmarked, so a bad byte leaves
   // only its own sector unprotected
   // sector marked: full byte for 1..15, sub-field for sector 0
   function automatic logic sec_marked(input logic [7:0] b,
                                       input logic [3:0] sec,
                                       input logic       sub_b);
      logic r;
      r = 1'b0;
      if (sec == 4'd0) begin
         if (sub_b) begin
            r = (b[spc_pkg::SUB_B_HI:spc_pkg::SUB_B_LO] == 2'b11);
         end else begin
            r = (b[spc_pkg::SUB_A_HI:spc_pkg::SUB_A_LO] == 2'b11);
         end
      end else begin
         r = (b == spc_pkg::SEL_MARKED);
      end
      return r;
   endfunction

   // a command acts only at a clean release in its armed state; a
   // trailing partial byte means the host changed its mind
   function automatic logic frame_acts(input spc_pkg::spc_cmd_st_t s,
                                       input spc_pkg::spc_cmd_st_t armed,
                                       input logic                 fe,
                                       input logic                 part);
      return fe & ~part & (s == armed);
   endfunction

   // ==========================================================
   // pin front ends
   // all four pins pass two flops inside the front ends; nothing below
   // reads a raw pin, so one metastable sample cannot split a decision
   spc_pkg::spc_byte_t rx_byte;
   logic               frame_start;
   logic               frame_end;
   logic               mid_byte;
   logic               wp_n_filt;

   // serial bytes, msb first, framed by chip select
   spc_spi_rx u_rx (
      .i_clk_sys     (i_clk_sys),
      .i_reset       (i_reset),
      .i_spi_sck     (i_spi_sck),
      .i_spi_cs_n    (i_spi_cs_n),
      .i_spi_si      (i_spi_si),
      .o_byte        (rx_byte),
      .o_frame_start (frame_start),
      .o_frame_end   (frame_end),
      .o_mid_byte    (mid_byte)
   );

   // write-protect level, debounced both ways
   spc_wp_filt #(
      .STABLE_CYC (WP_STABLE_CYC)
   ) u_wp (
      .i_clk_sys   (i_clk_sys),
      .i_reset     (i_reset),
      .i_wp_n      (i_wp_n),
      .o_wp_n_filt (wp_n_filt)
   );

   // ==========================================================
   // command sequence decoder
   // state follows the bytes of the current frame only
   spc_pkg::spc_cmd_st_t st_r;
   spc_pkg::spc_cmd_st_t st_nxt;

   // the decoder only follows bytes; the frame boundaries act on it.
   // a frame start rewinds, so an armed state left by a frame cut
   // short cannot carry into the next frame
   // each byte must match in order, else the frame goes dead
   always_comb begin
      st_nxt = st_r;
      if (frame_start) begin
         st_nxt = spc_pkg::ST_IDLE;
      end else if (rx_byte.valid) begin
         case (st_r)
            spc_pkg::ST_IDLE: begin
               st_nxt = (rx_byte.data == spc_pkg::CMD_PFX0) ?
                        spc_pkg::ST_PFX1 : spc_pkg::ST_DEAD;
            end
            spc_pkg::ST_PFX1: begin
               st_nxt = (rx_byte.data == spc_pkg::CMD_PFX1) ?
                        spc_pkg::ST_PFX2 : spc_pkg::ST_DEAD;
            end
            spc_pkg::ST_PFX2: begin
               st_nxt = (rx_byte.data == spc_pkg::CMD_PFX2) ?
                        spc_pkg::ST_LAST : spc_pkg::ST_DEAD;
            end
            spc_pkg::ST_LAST: begin
               if (rx_byte.data == spc_pkg::CMD_PROT_ON) begin
                  st_nxt = spc_pkg::ST_ARMON;
               end else if (rx_byte.data == spc_pkg::CMD_PROT_OFF) begin
                  st_nxt = spc_pkg::ST_ARMOF;
               end else begin
                  st_nxt = spc_pkg::ST_DEAD;
               end
            end
            default: begin
               // a fifth byte cancels an armed command
               st_nxt = spc_pkg::ST_DEAD;
            end
         endcase
      end
   end

   // select release returns to idle after the arm flags are read;
   // a release wins over a byte landing in the same cycle, which
   // happens when the last sck rise is sampled a cycle before release
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         st_r <= spc_pkg::ST_IDLE;
      end else if (frame_end) begin
         st_r <= spc_pkg::ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // software enable, acted on at chip select release only
   logic sw_en_r;
   logic wp_low;
   logic arm_on;
   logic arm_off;

   // filtered pin, low means hardware protection
   assign wp_low  = ~wp_n_filt;
   // trailing partial byte voids the command
   assign arm_on  = frame_acts(st_r, spc_pkg::ST_ARMON, frame_end, mid_byte);
   assign arm_off = frame_acts(st_r, spc_pkg::ST_ARMOF, frame_end, mid_byte);

   // both arms come from one frame end, so they never meet in a cycle;
   // off is dropped, not queued, while the pin holds low, and power-up
   // always starts unprotected by software
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         sw_en_r <= spc_pkg::SW_EN_RST;
      end else if (arm_on) begin
         sw_en_r <= 1'b1;
      end else if (arm_off && !wp_low) begin
         sw_en_r <= 1'b0;
      end
   end

   // ==========================================================
   // effective protection: pin can only add to software state
   logic prot_on;

   assign prot_on = sw_en_r | wp_low;

   // ==========================================================
   // status flags
   // status flag, pin low forces on, release falls back to sw
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_prot_en <= spc_pkg::SW_EN_RST;
      end else begin
         o_prot_en <= prot_on;
      end
   end

   // writable flag follows the filtered pin; both flags come from
   // flops so the engines see clean levels, one cycle after the filter
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_sel_wr_ok <= 1'b1;
      end else begin
         o_sel_wr_ok <= ~wp_low;
      end
   end
   // with no enable, release ends protection after filter
   // an enable before or during low keeps sw_en_r set

   // ==========================================================
   // selection register, one byte per sector
   // flops indexed by sector, no memory macro
   logic [7:0] sel_r [spc_pkg::SEL_BYTES];

   // writes refused while the pin holds it read-only
   // erase sets every byte to the marked value, so a stray program
   // right after an erase finds every sector marked, and blocked while protection is on
   // one process per byte keeps the erase to a single cycle
   genvar gi;
   generate
      for (gi = 0; gi < spc_pkg::SEL_BYTES; gi++) begin : g_sel
         always_ff @(posedge i_clk_sys or posedge i_reset) begin
            if (i_reset) begin
               sel_r[gi] <= spc_pkg::SEL_RST_VAL;
            end else if (i_sel_wr.valid && !wp_low) begin
               if (i_sel_wr.erase) begin
                  sel_r[gi] <= spc_pkg::SEL_ERASED;
               end else if (i_sel_wr.idx == 4'(gi)) begin
                  sel_r[gi] <= i_sel_wr.data;
               end
            end
         end
      end
   endgenerate

   // write outcome pulses, one per write request
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_sel_wr_done    <= 1'b0;
         o_sel_wr_refused <= 1'b0;
      end else begin
         o_sel_wr_done    <= i_sel_wr.valid & ~wp_low;
         o_sel_wr_refused <= i_sel_wr.valid & wp_low;
      end
   end

   // ==========================================================
   // read port
   // registered byte, readable whatever the pin level
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_sel_rd_data <= spc_pkg::SEL_CLEAR;
      end else begin
         o_sel_rd_data <= sel_r[i_sel_rd_idx];
      end
   end

   // ==========================================================
   // program/erase verdict, answered one cycle after the request
   // the register itself is guarded by the pin alone; the software
   // enable never blocks it
   logic blocked_nxt;

   // combinational look-up, registered below
   always_comb begin
      if (i_op_req.to_reg) begin
         blocked_nxt = wp_low;
      end else begin
         blocked_nxt = prot_on &
                       sec_marked(sel_r[i_op_req.sector],
                                  i_op_req.sector,
                                  i_op_req.sub_b);
      end
   end

   // verdict clears with no request, so a stale answer never looks
   // like a fresh one
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_op_verdict <= '0;
      end else begin
         o_op_verdict.valid   <= i_op_req.valid;
         o_op_verdict.blocked <= i_op_req.valid & blocked_nxt;
      end
   end

endmodule

//--- spc_prot_checker.sv
// spc_prot_checker: port-level assertions for spc_sector_protect
// assumes it is bound to the top module; pins are asynchronous
`timescale 1ns/1ps
module spc_prot_checker #(
   parameter int STABLE_CYC = 4
) (
   // watched ports
   input wire logic                  i_clk_sys,
   input wire logic                  i_reset,
   input wire logic                  i_spi_cs_n,
   input wire logic                  i_wp_n,
   input wire spc_pkg::spc_op_req_t  i_op_req,
   input wire spc_pkg::spc_verdict_t o_op_verdict,
   input wire spc_pkg::spc_sel_wr_t  i_sel_wr,
   input wire logic                  o_sel_wr_done,
   input wire logic                  o_sel_wr_refused,
   input wire logic                  o_prot_en,
   input wire logic                  o_sel_wr_ok
);
   // ==========================================================
   // pin run lengths and age of the last select release
   logic [7:0] lo_r;
   logic [7:0] hi_r;
   logic [7:0] age_r;
   logic       cs_r;
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         lo_r  <= 8'h00;
         hi_r  <= 8'h00;
         age_r <= 8'hff;
         cs_r  <= 1'b1;
      end else begin
         lo_r  <= i_wp_n ? 8'h00 : lo_r + {7'h00, lo_r != 8'hff};
         hi_r  <= !i_wp_n ? 8'h00 : hi_r + {7'h00, hi_r != 8'hff};
         age_r <= (i_spi_cs_n && !cs_r) ? 8'h00
                  : age_r + {7'h00, age_r != 8'hff};
         cs_r  <= i_spi_cs_n;
      end
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   // ==========================================================
   // assertions
   chk_verdict_pulse:
   assert property (i_op_req.valid |=> o_op_verdict.valid)
      else $error("verdict missing");
   chk_verdict_quiet:
   assert property (!i_op_req.valid |=> !o_op_verdict.valid)
      else $error("verdict without request");
   chk_reg_locked:
   assert property ((i_op_req.valid && i_op_req.to_reg && !o_sel_wr_ok
      && !$past(o_sel_wr_ok, 2)) ##1 !o_sel_wr_ok [*2]
      |-> $past(o_op_verdict.blocked)) else $error("register not locked");
   chk_wr_refused:
   assert property ((i_sel_wr.valid && !o_sel_wr_ok
      && !$past(o_sel_wr_ok, 2)) ##1 !o_sel_wr_ok [*2]
      |-> $past(o_sel_wr_refused)) else $error("write not refused");
   chk_wr_done:
   assert property ((i_sel_wr.valid && o_sel_wr_ok
      && $past(o_sel_wr_ok, 2)) ##1 o_sel_wr_ok [*2]
      |-> $past(o_sel_wr_done)) else $error("write not done");
   chk_lock_prot:
   assert property (!o_sel_wr_ok |-> o_prot_en)
      else $error("pin low without protection");
   chk_off_pin_high:
   assert property ($fell(o_prot_en) |-> o_sel_wr_ok)
      else $error("protection dropped while pin low");
   chk_rise_cause:
   assert property ($rose(o_prot_en) |-> !o_sel_wr_ok || age_r < 8'h0c)
      else $error("protection rose without cause");
   chk_wp_filter:
   assert property ($changed(o_sel_wr_ok)
      |-> (o_sel_wr_ok ? hi_r : lo_r) >= STABLE_CYC)
      else $error("pin glitch passed filter");
   chk_wp_lo_bound:
   assert property (lo_r == STABLE_CYC + 8 |-> !o_sel_wr_ok && o_prot_en)
      else $error("pin low not applied in time");
   chk_wp_hi_bound:
   assert property (hi_r == STABLE_CYC + 8 |-> o_sel_wr_ok)
      else $error("pin high not applied in time");
   cover property ($rose(o_prot_en) && o_sel_wr_ok);
   cover property (o_sel_wr_refused);
   cover property (o_op_verdict.blocked && !i_op_req.to_reg);
endmodule

//--- spc_host_model.sv
// spc_host_model: host shifting command frames and driving write protect
// assumes a 200 ns serial clock; pins are asynchronous to the device
`timescale 1ns/1ps
module spc_host_model (
   // serial and write-protect pins
   output logic o_sck,
   output logic o_cs_n,
   output logic o_si,
   output logic o_wp_n
);
   // ==========================================================
   // idle pins; serial clock stands low outside frames
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
      o_wp_n = 1'b1;
   end
   // nb bits of w, msb first, then select release
   task automatic frame(input logic [31:0] w, input int nb);
      o_cs_n = 1'b0;
      for (int i = 0; i < nb; i++) begin
         o_si = w[31-i];
         #100 o_sck = 1'b1;
         #100 o_sck = 1'b0;
      end
      o_si = ~o_si; // released line shows no stale bit
      #100 o_cs_n = 1'b1;
      #300;
   endtask
   // pin level held for ns
   task automatic wp(input logic v, input int ns);
      o_wp_n = v;
      #(ns);
   endtask
endmodule

//--- tb_sector_protect_control.sv
// tb_sector_protect_control: self-checking bench against a behavioural model
// assumes spc_host_model drives the pins; checker bound at the foot
`timescale 1ns/1ps
module tb_sector_protect_control;
   // ==========================================================
   // clock, reset and ports
   logic                  i_clk_sys = 1'b0;
   logic                  i_reset   = 1'b1;
   logic                  sck;
   logic                  cs_n;
   logic                  si;
   logic                  wp_n;
   spc_pkg::spc_op_req_t  op_req = '0;
   spc_pkg::spc_verdict_t verdict;
   spc_pkg::spc_sel_wr_t  sel_wr = '0;
   logic                  wr_done;
   logic                  wr_ref;
   logic                  prot_en;
   logic                  wr_ok;
   logic [3:0]            rd_idx = 4'h0;
   logic [7:0]            rd_data;
   localparam logic [23:0] PFX = {spc_pkg::CMD_PFX0, spc_pkg::CMD_PFX1,
                                  spc_pkg::CMD_PFX2};
   // model state
   int fails = 0;
   int num_checks = 0;
   int seed = 32'hd1ec;
   int sw_en = 0;
   int wp_lo = 0;
   int sel[16] = '{default: 0};
   always #12.5 i_clk_sys = ~i_clk_sys;
   spc_sector_protect #(.WP_STABLE_CYC(4)) dut (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_spi_sck(sck),
      .i_spi_cs_n(cs_n), .i_spi_si(si), .i_wp_n(wp_n),
      .i_op_req(op_req), .o_op_verdict(verdict), .i_sel_wr(sel_wr),
      .o_sel_wr_done(wr_done), .o_sel_wr_refused(wr_ref),
      .i_sel_rd_idx(rd_idx), .o_sel_rd_data(rd_data),
      .o_prot_en(prot_en), .o_sel_wr_ok(wr_ok));
   spc_host_model host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si),
                        .o_wp_n(wp_n));
   // ==========================================================
   // compares and verdict
   task automatic chk1(input string n, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s exp %b got %b", n, e, g);
      end
   endtask
   task automatic chk8(input string n, input logic [7:0] e,
                       input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ==========================================================
   // model helpers and stimulus tasks
   function automatic logic mk(int s, int b);
      if (s == 0)
         return b ? sel[0][5:4] == 2'h3 : sel[0][7:6] == 2'h3;
      return sel[s] == 255;
   endfunction
   task automatic st;
      repeat (16) @(posedge i_clk_sys);
      #1;
      chk1("prot_en", (sw_en | wp_lo) != 0, prot_en);
      chk1("sel_wr_ok", wp_lo == 0, wr_ok);
   endtask
   task automatic verdicts(input logic to_reg);
      logic e;
      for (int s = 0; s < 17; s++) begin
         @(posedge i_clk_sys) #1;
         op_req = '{1'b1, to_reg, s[3:0], s == 16};
         e = to_reg ? wp_lo != 0
                    : ((sw_en | wp_lo) != 0) && mk(s % 16, s / 16);
         @(posedge i_clk_sys) #1;
         op_req = '0;
         chk1("verdict_valid", 1'b1, verdict.valid);
         chk1("blocked", e, verdict.blocked);
      end
   endtask
   task automatic wr(input logic er, input int i, input int d);
      @(posedge i_clk_sys) #1;
      sel_wr = '{1'b1, er, i[3:0], d[7:0]};
      rd_idx = i[3:0];
      @(posedge i_clk_sys) #1;
      sel_wr = '0;
      chk1("wr_done", wp_lo == 0, wr_done);
      chk1("wr_refused", wp_lo != 0, wr_ref);
      for (int k = 0; k < 16 && wp_lo == 0; k++)
         if (er || k == i) sel[k] = er ? 255 : d & 255;
      @(posedge i_clk_sys) #1;
      chk8("rd_data", sel[i][7:0], rd_data);
   endtask
   task automatic cmd(input logic on);
      host.frame({PFX, on ? spc_pkg::CMD_PROT_ON : spc_pkg::CMD_PROT_OFF}, 32);
      if (on || wp_lo == 0) sw_en = on;
      st;
   endtask
   task automatic pin(input logic v);
      host.wp(v, 50); // short glitch first
      host.wp(!v, 200);
      host.wp(v, 0);
      wp_lo = !v;
      st;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      #2_000_000;
      fails++;
      report_and_stop;
   end
   initial begin
      repeat (10) @(posedge i_clk_sys);
      #1 i_reset = 1'b0;
      st;
      chk8("rd_reset", 8'h00, rd_data);
      for (int i = 0; i < 16; i++)
         wr(0, i, i == 0 ? $random(seed) : ($random(seed) & 1) * 255);
      verdicts(0);
      cmd(1);
      verdicts(0);
      host.frame({PFX, spc_pkg::CMD_PROT_OFF}, 24);
      st;
      host.frame({PFX, 8'h9b}, 32);
      st;
      cmd(0);
      pin(0);
      verdicts(0);
      verdicts(1);
      wr(0, 3, 0);
      pin(1);
      cmd(1);
      pin(0);
      cmd(0);
      pin(1);
      cmd(0);
      pin(0);
      cmd(1);
      pin(1);
      wr(1, 0, 0);
      verdicts(0);
      cmd(0);
      verdicts(1);
      cmd(1);
      // power cycle mid-run: enable and selection bytes come back cleared
      @(posedge i_clk_sys) #1 i_reset = 1'b1;
      repeat (10) @(posedge i_clk_sys);
      #1 i_reset = 1'b0;
      sw_en = 0;
      sel = '{default: 0};
      st;
      chk8("rd_reset", 8'h00, rd_data);
      report_and_stop;
   end
endmodule
bind spc_sector_protect spc_prot_checker #(.STABLE_CYC(WP_STABLE_CYC)) u_chk (
   .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_spi_cs_n(i_spi_cs_n),
   .i_wp_n(i_wp_n), .i_op_req(i_op_req), .o_op_verdict(o_op_verdict),
   .i_sel_wr(i_sel_wr), .o_sel_wr_done(o_sel_wr_done),
   .o_sel_wr_refused(o_sel_wr_refused), .o_prot_en(o_prot_en),
   .o_sel_wr_ok(o_sel_wr_ok));
